// [inc/icx_pkg.sv]
// shared constants and carrier types for the interline exposure/readout sequencer
// assumes a 125 MHz system clock and a single AHB-Lite slave port
package icx_pkg;
	localparam int unsigned CLK_MHZ        = 125;
	// register byte offsets
	localparam logic [7:0] OFF_CTRL        = 8'h00;
	localparam logic [7:0] OFF_EXP         = 8'h04;
	localparam logic [7:0] OFF_GEOM        = 8'h08;
	localparam logic [7:0] OFF_ROI_ROW     = 8'h0c;
	localparam logic [7:0] OFF_ROI_COL     = 8'h10;
	localparam logic [7:0] OFF_BIN         = 8'h14;
	localparam logic [7:0] OFF_STATUS      = 8'h18;
	localparam logic [7:0] OFF_PIXCLK      = 8'h1c;
	// control fields
	localparam int unsigned CTRL_RUN       = 0;
	localparam int unsigned CTRL_EXTSYNC   = 1;
	localparam int unsigned CTRL_EARLY     = 2;
	localparam int unsigned CTRL_SHTYPE    = 4;
	localparam int unsigned SHTYPE_W       = 2;
	// reset values
	localparam logic [31:0] RST_EXP        = 32'h0000_1000;
	localparam logic [31:0] RST_GEOM       = 32'h0406_0514; // 1030 rows, 1300 cols
	localparam logic [31:0] RST_ROI_ROW    = 32'h0405_0000;
	localparam logic [31:0] RST_ROI_COL    = 32'h0513_0000;
	localparam logic [31:0] RST_BIN        = 32'h0001_0001;
	localparam logic [15:0] RST_PIXCLK     = 16'h0001;
	// shutter compensation in microseconds per shutter type (0 = none)
	localparam int unsigned COMP_US_T1     = 8;
	localparam int unsigned COMP_US_T2     = 16;
	localparam int unsigned COMP_US_T3     = 28;
	localparam logic [31:0] COMP_CYC_T1    = 32'(COMP_US_T1 * CLK_MHZ);
	localparam logic [31:0] COMP_CYC_T2    = 32'(COMP_US_T2 * CLK_MHZ);
	localparam logic [31:0] COMP_CYC_T3    = 32'(COMP_US_T3 * CLK_MHZ);
	// transfer pulse widths in cycles
	localparam logic [15:0] XFER_CYC       = 16'h0008;
	localparam logic [15:0] VSHIFT_CYC     = 16'h0004;

	typedef enum logic [5:0] {
		ICX_IDLE  = 6'b000001,
		ICX_WAIT  = 6'b000010,
		ICX_EXP   = 6'b000100,
		ICX_COMP  = 6'b001000,
		ICX_XFER  = 6'b010000,
		ICX_READ  = 6'b100000
	} icx_state_t;

	typedef enum logic [2:0] {
		RD_VSHIFT = 3'b001,
		RD_HSHIFT = 3'b010,
		RD_DONE   = 3'b100
	} icx_rd_t;

	// outputs toward the sensor array
	typedef struct packed {
		logic readout_active_n;
		logic imaging_enable;
		logic xfer_gate;
		logic vshift;
		logic hshift;
		logic hdump;
		logic pix_valid;
		logic frame_done;
	} icx_ccd_t;

	typedef struct packed {
		logic [1:0]  hresp;
		logic        hreadyout;
		logic [31:0] hrdata;
	} icx_ahb_out_t;
endpackage

// [rtl/icx_regs.sv]
// register store for the sequencer: small memory, registered read data
// assumes single-word writes from the bus slave in the same clock domain
module icx_regs (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        ce,
	input  wire logic        we,
	input  wire logic [2:0]  waddr,
	input  wire logic [31:0] wdata,
	input  wire logic [2:0]  raddr,
	output logic      [31:0] rdata,
	output logic      [31:0] ctrl,
	output logic      [31:0] exp_cyc,
	output logic      [31:0] geom,
	output logic      [31:0] roi_row,
	output logic      [31:0] roi_col,
	output logic      [31:0] bin,
	output logic      [31:0] pixclk
);
	logic [31:0] mem_r [8];

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_word
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					case (gi)
						1: mem_r[gi] <= icx_pkg::RST_EXP;
						2: mem_r[gi] <= icx_pkg::RST_GEOM;
						3: mem_r[gi] <= icx_pkg::RST_ROI_ROW;
						4: mem_r[gi] <= icx_pkg::RST_ROI_COL;
						5: mem_r[gi] <= icx_pkg::RST_BIN;
						7: mem_r[gi] <= {16'h0000, icx_pkg::RST_PIXCLK};
						default: mem_r[gi] <= 32'h0000_0000;
					endcase
				end else if (ce && we && waddr == 3'(gi)) begin
					mem_r[gi] <= wdata;
				end
			end
		end
	endgenerate

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rdata <= 32'h0000_0000;
		end else if (ce) begin
			rdata <= mem_r[raddr];
		end
	end

	assign ctrl    = mem_r[0];
	assign exp_cyc = mem_r[1];
	assign geom    = mem_r[2];
	assign roi_row = mem_r[3];
	assign roi_col = mem_r[4];
	assign bin     = mem_r[5];
	assign pixclk  = mem_r[7];
endmodule

// [rtl/icx_seq.sv]
// interline exposure and readout sequencer with AHB-Lite register slave
// assumes ext_sync arrives asynchronously; sensor clocks go to level-shifting drivers
// Operation
// (R1) overlapped default, non-overlapped when exposure shorter
// (R2) software programs exposure length
// (R3) readout_active_n low only during readout
// (R4) shutter-type compensation after exposure, automatic
// (R5) readout starts with image-to-storage transfer
// (R6) shift rows, clock each out, until empty; code stops after the last roi row, rows beyond it stay unshifted
// (R7) overlapped: new exposure starts at transfer
// (R8) overlapped: integration continues through and past readout
// (R9) non-overlapped: no exposure before readout done
// (R10) non-overlapped: imaging cells off during readout
// (R11) free-run non-overlapped: re-enable immediately after readout
// (R12) ext-sync no early-open: wait for sync pulse
// (R13) region-of-interest readout at full resolution
// (R14) rectangular hardware binning before output amplifier
// (R15) ext-sync: overlapped only, one frame per pulse
// (R16) trigger source pulses before each next readout
// (R17) counters time intervals, reset returns idle
//
// Decided for this implementation: register access over AHB-Lite and the register offsets.
module icx_seq (
	input  wire logic                 hclk,
	input  wire logic                 hresetn,
	input  wire logic                 ce,
	input  wire logic                 hsel,
	input  wire logic [7:0]           haddr,
	input  wire logic [1:0]           htrans,
	input  wire logic                 hwrite,
	input  wire logic [2:0]           hsize,
	input  wire logic [31:0]          hwdata,
	input  wire logic                 hready,
	output icx_pkg::icx_ahb_out_t     ahb_o,
	input  wire logic                 ext_sync,
	output icx_pkg::icx_ccd_t         ccd_o
);
	typedef struct packed {
		icx_pkg::icx_state_t st;
		icx_pkg::icx_rd_t    rd;
		logic [2:0]  sync_sh;
		logic        sync_lvl;
		logic        sync_seen;
		logic        ovl;
		logic        exp_run;
		logic [31:0] exp_cnt;
		logic [31:0] cnt;
		logic [15:0] row;
		logic [15:0] col;
		logic [15:0] bcnt;
		logic [15:0] pcnt;
		logic        wpend;
		logic [2:0]  waddr;
		logic [31:0] frames;
		icx_pkg::icx_ccd_t ccd;
	} icx_st_t;

	icx_st_t s_r;
	icx_st_t s_nxt;

	logic [31:0] ctrl;
	logic [31:0] exp_cyc;
	logic [31:0] geom;
	logic [31:0] roi_row;
	logic [31:0] roi_col;
	logic [31:0] bin;
	logic [31:0] pixclk;
	logic [31:0] regs_rdata;
	logic [31:0] status_w;
	logic [31:0] rdata_r;
	logic        rd_stat_r;
	logic [31:0] t_read;
	logic [31:0] t_comp;
	logic        addr_ok;
	logic        sync_rise;
	logic        rows_last;
	logic        cols_last;

	wire         acc = hsel && hready && htrans[1];
	assign addr_ok = (haddr[1:0] == 2'b00) && (haddr <= icx_pkg::OFF_PIXCLK);

	icx_regs u_regs (
		.hclk    (hclk),
		.hresetn (hresetn),
		.ce      (ce),
		.we      (s_r.wpend),
		.waddr   (s_r.waddr),
		.wdata   (hwdata),
		.raddr   (haddr[4:2]),
		.rdata   (regs_rdata),
		.ctrl    (ctrl),
		.exp_cyc (exp_cyc),
		.geom    (geom),
		.roi_row (roi_row),
		.roi_col (roi_col),
		.bin     (bin),
		.pixclk  (pixclk)
	);

	// status word: state, mode, frame count
	assign status_w = {s_r.frames[15:0], 2'b00, s_r.ovl, s_r.exp_run, s_r.sync_seen,
		s_r.ccd.readout_active_n, 4'h0, s_r.st};

	// (R4) compensation per shutter type, no user setting
	always_comb begin
		case (ctrl[icx_pkg::CTRL_SHTYPE +: icx_pkg::SHTYPE_W])
			2'd1:    t_comp = icx_pkg::COMP_CYC_T1;
			2'd2:    t_comp = icx_pkg::COMP_CYC_T2;
			2'd3:    t_comp = icx_pkg::COMP_CYC_T3;
			default: t_comp = 32'h0000_0000;
		endcase
	end

	// rough readout estimate: rows of roi over vertical bin times per-row cost
	assign t_read = 32'((roi_row[31:16] - roi_row[15:0] + 16'h0001) / bin[15:0]) *
		32'(32'(icx_pkg::VSHIFT_CYC) + 32'((roi_col[31:16] - roi_col[15:0] + 16'h0001)
		/ bin[31:16]) * 32'(pixclk[15:0]) + 32'(geom[15:0]));

	// a rise counts only once the second and third stages agree
	assign sync_rise = s_r.sync_sh[2] && s_r.sync_sh[1] && !s_r.sync_lvl;
	// (R13) roi row end bounds the vertical shifts, roi columns only gate pix_valid
	assign rows_last = s_r.row >= roi_row[31:16];
	assign cols_last = s_r.col > roi_col[31:16];

	always_comb begin
		s_nxt = s_r;
		s_nxt.ccd.xfer_gate  = 1'b0;
		s_nxt.ccd.vshift     = 1'b0;
		s_nxt.ccd.hshift     = 1'b0;
		s_nxt.ccd.hdump      = 1'b0;
		s_nxt.ccd.pix_valid  = 1'b0;
		s_nxt.ccd.frame_done = 1'b0;
		// sync: change counts once second and third stage agree
		s_nxt.sync_sh = {s_r.sync_sh[1:0], ext_sync};
		if (s_r.sync_sh[2] == s_r.sync_sh[1]) begin
			s_nxt.sync_lvl = s_r.sync_sh[2];
		end
		// consumption wins over a sync event in the same cycle
		if (sync_rise && ctrl[icx_pkg::CTRL_EXTSYNC]) begin
			s_nxt.sync_seen = 1'b1;
		end
		// bus: latch write address phase
		s_nxt.wpend = acc && hwrite && addr_ok && haddr[4:2] != 3'd6;
		s_nxt.waddr = haddr[4:2];
		// (R8) exposure counter runs independently of readout
		if (s_r.exp_run && s_r.exp_cnt != 32'h0000_0000) begin
			s_nxt.exp_cnt = s_r.exp_cnt - 32'h0000_0001;
		end
		case (s_r.st)
			icx_pkg::ICX_IDLE: begin
				s_nxt.ccd.readout_active_n = 1'b1;
				s_nxt.ccd.imaging_enable   = 1'b0;
				if (ctrl[icx_pkg::CTRL_RUN]) begin
					// (R1) mode picked from exposure against readout time
					// (R15) ext-sync forces overlapped
					s_nxt.ovl = ctrl[icx_pkg::CTRL_EXTSYNC] || !(exp_cyc < t_read);
					s_nxt.sync_seen = sync_rise && ctrl[icx_pkg::CTRL_EXTSYNC];
					s_nxt.st = ctrl[icx_pkg::CTRL_EXTSYNC] ? icx_pkg::ICX_WAIT
						: icx_pkg::ICX_EXP;
					if (!ctrl[icx_pkg::CTRL_EXTSYNC]) begin
						// (R2) load programmed exposure
						s_nxt.exp_cnt = exp_cyc;
						s_nxt.exp_run = 1'b1;
						s_nxt.ccd.imaging_enable = 1'b1;
					end
				end
			end
			icx_pkg::ICX_WAIT: begin
				// (R12) imaging stays off until sync detected unless CTRL_EARLY is set
				s_nxt.ccd.imaging_enable = ctrl[icx_pkg::CTRL_EARLY];
				if (!ctrl[icx_pkg::CTRL_RUN]) begin
					s_nxt.st = icx_pkg::ICX_IDLE;
				end else if (s_r.sync_seen || sync_rise) begin
					s_nxt.sync_seen = 1'b0;
					s_nxt.exp_cnt = exp_cyc;
					s_nxt.exp_run = 1'b1;
					s_nxt.ccd.imaging_enable = 1'b1;
					s_nxt.st = icx_pkg::ICX_EXP;
				end
			end
			icx_pkg::ICX_EXP: begin
				// (R3) indicator high while exposing
				s_nxt.ccd.readout_active_n = 1'b1;
				if (s_r.exp_cnt == 32'h0000_0000) begin
					s_nxt.exp_run = 1'b0;
					s_nxt.cnt = t_comp;
					s_nxt.st = icx_pkg::ICX_COMP;
				end
			end
			icx_pkg::ICX_COMP: begin
				// (R17) compensation counted in system clocks
				if (s_r.cnt == 32'h0000_0000) begin
					s_nxt.cnt = 32'(icx_pkg::XFER_CYC);
					s_nxt.ccd.readout_active_n = 1'b0;
					s_nxt.ccd.xfer_gate = 1'b1;
					s_nxt.st = icx_pkg::ICX_XFER;
				end else begin
					s_nxt.cnt = s_r.cnt - 32'h0000_0001;
				end
			end
			icx_pkg::ICX_XFER: begin
				// (R5) image cells dumped into storage first
				s_nxt.ccd.xfer_gate = s_r.cnt > 32'h0000_0001;
				if (s_r.cnt == 32'h0000_0001) begin
					s_nxt.row = 16'h0000;
					s_nxt.bcnt = 16'h0000;
					s_nxt.cnt = 32'(icx_pkg::VSHIFT_CYC);
					s_nxt.rd = icx_pkg::RD_VSHIFT;
					s_nxt.st = icx_pkg::ICX_READ;
					if (s_r.ovl) begin
						// (R7) next exposure starts with the transfer
						s_nxt.exp_cnt = exp_cyc;
						s_nxt.exp_run = 1'b1;
					end else begin
						// (R10) imaging off for whole readout
						// (R9) no exposure until readout done
						s_nxt.ccd.imaging_enable = 1'b0;
					end
				end else begin
					s_nxt.cnt = s_r.cnt - 32'h0000_0001;
				end
			end
			icx_pkg::ICX_READ: begin
				s_nxt.ccd.readout_active_n = 1'b0;
				case (s_r.rd)
					icx_pkg::RD_VSHIFT: begin
						// (R14) vertical bin: several rows summed in register
						s_nxt.ccd.vshift = 1'b1;
						if (s_r.cnt == 32'h0000_0001) begin
							s_nxt.row = s_r.row + 16'h0001;
							s_nxt.bcnt = s_r.bcnt + 16'h0001;
							s_nxt.cnt = 32'(icx_pkg::VSHIFT_CYC);
							// (R13) rows before the roi start are dumped unread
							if (s_r.row < roi_row[15:0]) begin
								s_nxt.ccd.hdump = 1'b1;
								s_nxt.bcnt = 16'h0000;
							end else if (s_r.bcnt + 16'h0001 >= bin[15:0] || rows_last) begin
								s_nxt.bcnt = 16'h0000;
								s_nxt.col = 16'h0000;
								s_nxt.pcnt = 16'h0000;
								s_nxt.rd = icx_pkg::RD_HSHIFT;
							end
						end else begin
							s_nxt.cnt = s_r.cnt - 32'h0000_0001;
						end
					end
					icx_pkg::RD_HSHIFT: begin
						// (R6) clock row out one pixel group at a time
						// (R14) horizontal bin: several shifts per sample
						s_nxt.ccd.hshift = 1'b1;
						s_nxt.pcnt = s_r.pcnt + 16'h0001;
						if (s_r.pcnt + 16'h0001 >= pixclk[15:0]) begin
							s_nxt.pcnt = 16'h0000;
							s_nxt.col = s_r.col + 16'h0001;
							s_nxt.bcnt = s_r.bcnt + 16'h0001;
							if (s_r.bcnt + 16'h0001 >= bin[31:16]) begin
								s_nxt.bcnt = 16'h0000;
								s_nxt.ccd.pix_valid = s_r.col >= roi_col[15:0] && !cols_last;
							end
							if (s_r.col + 16'h0001 >= geom[15:0]) begin
								s_nxt.bcnt = 16'h0000;
								s_nxt.rd = (s_r.row > roi_row[31:16]) ? icx_pkg::RD_DONE
									: icx_pkg::RD_VSHIFT;
							end
						end
					end
					default: begin
						// (R6) end of frame: one hdump pulse; rows beyond roi are not shifted out
						s_nxt.ccd.hdump = 1'b1;
						s_nxt.ccd.frame_done = 1'b1;
						s_nxt.frames = s_r.frames + 32'h0000_0001;
						s_nxt.ccd.readout_active_n = 1'b1;
						if (!ctrl[icx_pkg::CTRL_RUN]) begin
							s_nxt.exp_run = 1'b0;
							s_nxt.st = icx_pkg::ICX_IDLE;
						end else if (s_r.ovl) begin
							// (R8) free-run: exposure already running, finish it; ext-sync clears exp_run and waits
							// (R15) ext-sync needs a fresh pulse per frame
							// (R16) relies on trigger before next readout
							if (ctrl[icx_pkg::CTRL_EXTSYNC]) begin
								s_nxt.exp_run = 1'b0;
								s_nxt.st = icx_pkg::ICX_WAIT;
							end else begin
								s_nxt.st = icx_pkg::ICX_EXP;
							end
						end else if (ctrl[icx_pkg::CTRL_EXTSYNC]) begin
							s_nxt.st = icx_pkg::ICX_WAIT;
						end else begin
							// (R11) free-run: imaging back on at once
							s_nxt.ccd.imaging_enable = 1'b1;
							s_nxt.exp_cnt = exp_cyc;
							s_nxt.exp_run = 1'b1;
							s_nxt.st = icx_pkg::ICX_EXP;
						end
					end
				endcase
			end
			default: begin
				s_nxt.st = icx_pkg::ICX_IDLE;
			end
		endcase
		// mode re-evaluated each frame so a changed exposure switches mode
		if (s_r.st != icx_pkg::ICX_READ && s_nxt.st == icx_pkg::ICX_READ) begin
			s_nxt.ovl = s_r.ovl;
		end
		if (s_r.st == icx_pkg::ICX_READ && s_nxt.st != icx_pkg::ICX_READ) begin
			// (R1) next frame re-picks mode
			s_nxt.ovl = ctrl[icx_pkg::CTRL_EXTSYNC] || !(exp_cyc < t_read);
		end
	end

	// (R17) reset returns to idle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_r <= '{st: icx_pkg::ICX_IDLE, rd: icx_pkg::RD_DONE,
				ccd: '{readout_active_n: 1'b1, default: 1'b0}, default: '0};
		end else if (ce) begin
			s_r <= s_nxt;
		end
	end

	// data phase read mux; status live, others from store
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_stat_r <= 1'b0;
			rdata_r   <= 32'h0000_0000;
		end else if (ce) begin
			rd_stat_r <= acc && !hwrite && haddr[4:2] == 3'd6;
			rdata_r   <= status_w;
		end
	end

	// zero wait state, always OKAY; unmapped reads return the store word at haddr[4:2], or the status word when haddr[4:2] is 6
	assign ahb_o.hreadyout = 1'b1;
	assign ahb_o.hresp     = 2'b00;
	assign ahb_o.hrdata    = rd_stat_r ? rdata_r : regs_rdata;
	assign ccd_o           = s_r.ccd;
endmodule

// [dv/icx_seq_properties.sv]
// port checker for the exposure/readout sequencer
// assumes one clock domain, reset low asynchronous
module icx_seq_properties (
	input wire logic              hclk,
	input wire logic              hresetn,
	input wire logic              ce,
	input icx_pkg::icx_ahb_out_t  ahb_o,
	input icx_pkg::icx_ccd_t      ccd_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_resp_okay: assert property (ahb_o.hresp == 2'b00)
		else $error("bus response not okay");
	a_ready_high: assert property (ahb_o.hreadyout)
		else $error("bus slave stalled");
	a_xfer_busy: assert property (ccd_o.xfer_gate |-> !ccd_o.readout_active_n)
		else $error("transfer outside readout");
	a_shift_busy: assert property ((ccd_o.vshift || ccd_o.hshift) |-> !ccd_o.readout_active_n)
		else $error("shift outside readout");
	a_xfer_width: assert property ($rose(ccd_o.xfer_gate) |-> ccd_o.xfer_gate[*8] ##1 !ccd_o.xfer_gate)
		else $error("transfer gate width wrong");
	a_done_pulse: assert property (ccd_o.frame_done |=> !ccd_o.frame_done)
		else $error("frame done longer than one cycle");
	a_done_end: assert property (ccd_o.frame_done |-> ##[0:2] ccd_o.readout_active_n)
		else $error("readout not over at frame done");
	a_ce_freeze: assert property (!ce |=> $stable(ccd_o))
		else $error("outputs moved while frozen");
	a_pix_busy: assert property (ccd_o.pix_valid |-> !ccd_o.readout_active_n)
		else $error("pixel outside readout");
endmodule

bind icx_seq icx_seq_properties i_icx_seq_properties (
	.hclk    (hclk),
	.hresetn (hresetn),
	.ce      (ce),
	.ahb_o   (ahb_o),
	.ccd_o   (ccd_o)
);

// [dv/icx_array_model.sv]
// sensor array and sync source seen from the sequencer pins
// assumes fire is a one-cycle request from the bench
module icx_array_model (
	input wire logic          hclk,
	input wire logic          hresetn,
	input icx_pkg::icx_ccd_t  ccd,
	input wire logic          fire,
	output logic              ext_sync,
	output logic [31:0]       pix,
	output logic [31:0]       frames,
	output logic [31:0]       dark,
	output logic [31:0]       per
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] cyc;
	logic [3:0]  sync_cnt;

	// sync pulse held long enough to be seen
	assign ext_sync = (sync_cnt != 4'h0);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			{pix, frames, dark, per, cyc} <= '0;
			sync_cnt <= 4'h0;
		end else begin
			sync_cnt <= fire ? 4'h8 : sync_cnt - (sync_cnt != 4'h0);
			pix <= pix + ccd.pix_valid;
			frames <= frames + ccd.frame_done;
			// dark readout cycles: cells off while the frame is shifted out
			dark <= dark + (!ccd.readout_active_n && !ccd.imaging_enable);
			cyc <= ccd.frame_done ? 32'h0 : cyc + 32'h1;
			if (ccd.frame_done) begin
				per <= cyc;
			end
		end
	end
endmodule

// [dv/interline_ccd_exposure_readout_seq_tb.sv]
// self-checking bench: bus master, frame table, then reset and sync cases
// assumes the array model on the sensor side
module interline_ccd_exposure_readout_seq_tb;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic [31:0] ctrl, expt, rr, rc, bn, pix, dark, minp;
	} icx_case_t;
	localparam logic [31:0] FULL = 32'h0003_0000;
	localparam logic [31:0] B1 = 32'h0001_0001;
	localparam icx_case_t CASES [5] = '{
		'{32'h1, 32'd400, FULL, FULL, B1, 32'd16, 32'd0, 32'd400},
		'{32'h1, 32'd2, FULL, FULL, B1, 32'd16, 32'd1, 32'd2},
		'{32'h1, 32'd400, 32'h0002_0001, 32'h0002_0001, B1, 32'd4, 32'd0, 32'd400},
		'{32'h1, 32'd400, FULL, FULL, 32'h0002_0002, 32'd4, 32'd0, 32'd400},
		'{32'h11, 32'd400, FULL, FULL, B1, 32'd16, 32'd0, 32'd400 + icx_pkg::COMP_CYC_T1}
	};
	logic hclk, hresetn, ce, hsel, hwrite, fire, ext_sync;
	logic [7:0]  haddr;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] hwdata, q, pix, frames, dark, per, p0, d0;
	wire logic   hready;
	icx_pkg::icx_ahb_out_t ahb_o;
	icx_pkg::icx_ccd_t     ccd_o;
	integer n_fail, checks_done;

	assign hready = ahb_o.hreadyout;

	icx_seq i_icx_seq (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.ahb_o(ahb_o), .ext_sync(ext_sync), .ccd_o(ccd_o));
	icx_array_model i_icx_array_model (.hclk(hclk), .hresetn(hresetn), .ccd(ccd_o),
		.fire(fire), .ext_sync(ext_sync), .pix(pix), .frames(frames), .dark(dark), .per(per));

	initial begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end

	task give_verdict;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
		end
	endtask

	// address phase held until ready, data phase likewise; read data taken at the falling edge inside the data phase
	task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= w;
		hsize <= 3'b010;
		do @(negedge hclk); while (!hready);
		@(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(negedge hclk); while (!hready);
		q = ahb_o.hrdata;
		@(posedge hclk);
	endtask

	task rst;
		hresetn <= 1'b0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
	endtask

	task start(input icx_case_t c);
		rst;
		bus(icx_pkg::OFF_GEOM, 1'b1, 32'h0004_0004);
		bus(icx_pkg::OFF_ROI_ROW, 1'b1, c.rr);
		bus(icx_pkg::OFF_ROI_COL, 1'b1, c.rc);
		bus(icx_pkg::OFF_BIN, 1'b1, c.bn);
		bus(icx_pkg::OFF_EXP, 1'b1, c.expt);
		bus(icx_pkg::OFF_CTRL, 1'b1, c.ctrl);
	endtask

	task wait_done;
		int t;
		t = 0;
		do begin
			@(negedge hclk);
			t++;
		end while (!ccd_o.frame_done && t < 6000);
		if (!ccd_o.frame_done) begin
			n_fail++;
			$display("unexpected at %0t: no frame done in time", $time);
		end
		@(posedge hclk);
	endtask

	initial begin
		repeat (60000) @(posedge hclk);
		n_fail++;
		give_verdict;
	end

	initial begin
		{hresetn, hsel, hwrite, fire, htrans, haddr, hsize, hwdata} = '0;
		{n_fail, checks_done} = '0;
		ce = 1'b1;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		for (int i = 0; i < 5; i++) begin
			start(CASES[i]);
			wait_done;
			if (CASES[i].dark != 0) begin
				for (int k = 0; k < 4 && !ccd_o.imaging_enable; k++) @(negedge hclk);
				chk({31'h0, ccd_o.imaging_enable}, 32'h1, "imaging restart");
			end
			@(negedge hclk);
			p0 = pix;
			d0 = dark;
			wait_done;
			@(negedge hclk);
			chk(pix - p0, CASES[i].pix, "pixels per frame");
			chk({31'h0, dark != d0}, CASES[i].dark, "cells off in readout");
			chk({31'h0, per >= CASES[i].minp}, 32'h1, "frame period");
			$display("case %0d done", i);
		end
		// reset in mid readout, then reset values over the bus
		do @(negedge hclk); while (ccd_o.readout_active_n);
		@(posedge hclk);
		hresetn <= 1'b0;
		@(negedge hclk);
		chk({24'h0, ccd_o}, 32'h80, "outputs in reset");
		chk(ahb_o.hrdata, 32'h0, "read data in reset");
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(icx_pkg::OFF_EXP, 1'b0, 32'h0);
		chk(q, icx_pkg::RST_EXP, "exposure reset value");
		bus(icx_pkg::OFF_GEOM, 1'b0, 32'h0);
		chk(q, icx_pkg::RST_GEOM, "geometry reset value");
		bus(icx_pkg::OFF_STATUS, 1'b0, 32'h0);
		chk(q, 32'h0000_0401, "status after reset");
		bus(8'h20, 1'b0, 32'h0);
		chk(q, 32'h0, "unmapped read");
		$display("reset case done");
		// sync mode: nothing without a pulse, one frame per pulse, cells kept on
		start('{32'h3, 32'd2, FULL, FULL, B1, 32'd0, 32'd0, 32'd0});
		@(negedge hclk);
		p0 = frames;
		d0 = dark;
		repeat (150) @(posedge hclk);
		ce <= 1'b0;
		repeat (50) @(posedge hclk);
		ce <= 1'b1;
		repeat (100) @(negedge hclk);
		chk(frames - p0, 32'h0, "frame without sync");
		@(posedge hclk);
		fire <= 1'b1;
		@(posedge hclk);
		fire <= 1'b0;
		wait_done;
		repeat (400) @(negedge hclk);
		chk(frames - p0, 32'h1, "frames per pulse");
		chk(dark - d0, 32'h0, "sync mode overlapped");
		$display("sync case done");
		give_verdict;
	end
endmodule
